// *** fxc_pkg.sv ***
// fxc_pkg: constants shared by the strobe-driven fifo host controller
// assumes a 200 MHz aclk and the slowest speed grade of the fifo device
package fxc_pkg;

  // ------------------------------------------------------------------
  // widths
  // ------------------------------------------------------------------
  localparam int FXC_WORD_W = 9;
  localparam int FXC_ADDR_W = 5;
  localparam int FXC_CNT_W = 8;
  localparam int FXC_SYNC_W = FXC_WORD_W + 3;

  // ------------------------------------------------------------------
  // register offsets (byte addresses)
  // ------------------------------------------------------------------
  localparam logic [FXC_ADDR_W-1:0] FXC_REG_CTRL = 5'h00;
  localparam logic [FXC_ADDR_W-1:0] FXC_REG_CMD = 5'h04;
  localparam logic [FXC_ADDR_W-1:0] FXC_REG_WDATA = 5'h08;
  localparam logic [FXC_ADDR_W-1:0] FXC_REG_RDATA = 5'h0c;
  localparam logic [FXC_ADDR_W-1:0] FXC_REG_STATUS = 5'h10;

  // ------------------------------------------------------------------
  // field positions
  // ------------------------------------------------------------------
  localparam int FXC_CTRL_DEPTH = 0;
  localparam int FXC_CTRL_FIRST = 1;
  localparam int FXC_CMD_CLEAR = 0;
  localparam int FXC_CMD_REWIND = 1;
  localparam int FXC_CMD_READ = 2;
  localparam int FXC_ST_BUSY = 0;
  localparam int FXC_ST_EMPTY = 1;
  localparam int FXC_ST_FULL = 2;
  localparam int FXC_ST_HALF = 3;
  localparam int FXC_ST_REFUSED = 4;
  localparam int FXC_SY_EMPTY = FXC_WORD_W;
  localparam int FXC_SY_FULL = FXC_WORD_W + 1;
  localparam int FXC_SY_HALF = FXC_WORD_W + 2;

  localparam logic [1:0] FXC_RESP_OKAY = 2'h0;
  localparam logic [1:0] FXC_RESP_SLVERR = 2'h2;

  // ------------------------------------------------------------------
  // timing
  // ------------------------------------------------------------------
  localparam int FXC_CLK_NS = 5;
  localparam int FXC_STROBE_NS = 200;
  localparam int FXC_RECOV_NS = 35;
  localparam int FXC_SYNC_CYC = 2;
  localparam int FXC_STROBE_CYC = (FXC_STROBE_NS + FXC_CLK_NS - 1) / FXC_CLK_NS;
  localparam int FXC_RECOV_CYC = (FXC_RECOV_NS + FXC_CLK_NS - 1) / FXC_CLK_NS;
  localparam logic [FXC_CNT_W-1:0] FXC_STROBE_LAST = FXC_CNT_W'(FXC_STROBE_CYC - 1);
  localparam logic [FXC_CNT_W-1:0] FXC_READ_LAST =
    FXC_CNT_W'(FXC_STROBE_CYC + FXC_SYNC_CYC - 1);
  localparam logic [FXC_CNT_W-1:0] FXC_RECOV_LAST = FXC_CNT_W'(FXC_RECOV_CYC - 1);
  localparam logic [FXC_CNT_W-1:0] FXC_CNT_ZERO = 8'h00;
  localparam logic [FXC_CNT_W-1:0] FXC_CNT_ONE = 8'h01;

  // ------------------------------------------------------------------
  // types
  // ------------------------------------------------------------------
  typedef enum logic [1:0] {
    FXC_IDLE = 2'b00,
    FXC_ACT = 2'b01,
    FXC_REC = 2'b10
  } fxc_state_t;

  typedef enum logic [1:0] {
    FXC_OP_CLEAR = 2'b00,
    FXC_OP_WRITE = 2'b01,
    FXC_OP_READ = 2'b10,
    FXC_OP_REWIND = 2'b11
  } fxc_op_t;

endpackage

// *** fxc_sync.sv ***
// fxc_sync: two-flop synchroniser for a group of pin inputs
// assumes each bit is an independent level from outside the aclk domain
`timescale 1ns/1ps
`default_nettype none
module fxc_sync #(
  parameter int W = 1
) (
  // clock and control
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic ce,
  // levels
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  genvar i;
  generate
    for (i = 0; i < W; i++)
    begin : g_bit
      logic meta;
      always_ff @(posedge aclk)
      begin
        if (!aresetn)
        begin
          meta <= 1'b1;
          q[i] <= 1'b1;
        end
        else if (ce)
        begin
          meta <= d[i];
          q[i] <= meta;
        end
      end
    end
  endgenerate
endmodule
`default_nettype wire

// *** fxc_host.sv ***
// fxc_host: host controller driving a strobe-based fifo device over its pins
// assumes an axi4-lite master on aclk and device pins outside the clock domain
//
// What this block does
// - wide systems join control inputs; flags may come from any one device
// - depth chains combine all full flags and all empty flags externally
// - only the first chained device gets first-load low, others high
// - rewind is never used in depth mode
// - each token output is wired to the next device's token input
// - token-in pulses meet setup, width and recovery around strobes; the host never times its strobes against the token input
// - each host watches the flag that belongs to its own direction
`timescale 1ns/1ps
`default_nettype none
module fxc_host (
  // clock, reset, enable
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic ce,
  // axi4-lite write
  input wire logic [fxc_pkg::FXC_ADDR_W-1:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  // axi4-lite read
  input wire logic [fxc_pkg::FXC_ADDR_W-1:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  // device control pins
  output logic clear_n,
  output logic write_n,
  output logic read_n,
  output logic first_or_rewind_n,
  output logic chain_token_in_n,
  output logic chain_token_in_oe_n,
  output logic [fxc_pkg::FXC_WORD_W-1:0] fifo_wdata,
  // device status and data pins
  input wire logic [fxc_pkg::FXC_WORD_W-1:0] fifo_rdata,
  input wire logic empty_flag_n,
  input wire logic full_flag_n,
  input wire logic half_marker_n
);
  import fxc_pkg::*;

  // ------------------------------------------------------------------
  // pin synchronisers
  // ------------------------------------------------------------------
  logic [FXC_SYNC_W-1:0] sync_q;
  logic sync_empty_n;
  logic sync_full_n;
  logic sync_half_n;
  logic [FXC_WORD_W-1:0] sync_rdata;

  fxc_sync #(.W(FXC_SYNC_W)) u_sync (
    .aclk(aclk),
    .aresetn(aresetn),
    .ce(ce),
    .d({half_marker_n, full_flag_n, empty_flag_n, fifo_rdata}),
    .q(sync_q)
  );

  assign sync_empty_n = sync_q[FXC_SY_EMPTY];
  assign sync_full_n = sync_q[FXC_SY_FULL];
  assign sync_half_n = sync_q[FXC_SY_HALF];
  assign sync_rdata = sync_q[FXC_WORD_W-1:0];

  // ------------------------------------------------------------------
  // axi write channel
  // ------------------------------------------------------------------
  fxc_state_t state;
  logic op_pend;
  logic wr_fire;
  logic wr_known;

  assign wr_fire = awready;
  assign wr_known = (awaddr == FXC_REG_CTRL) || (awaddr == FXC_REG_CMD) ||
                    (awaddr == FXC_REG_WDATA);

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      awready <= 1'b0;
      wready <= 1'b0;
      bvalid <= 1'b0;
      bresp <= FXC_RESP_OKAY;
    end
    else if (ce)
    begin
      if (awready)
      begin
        awready <= 1'b0;
        wready <= 1'b0;
        bvalid <= 1'b1;
        bresp <= wr_known ? FXC_RESP_OKAY : FXC_RESP_SLVERR;
      end
      else if (bvalid)
      begin
        if (bready)
          bvalid <= 1'b0;
      end
      else if (awvalid && wvalid && state == FXC_IDLE && !op_pend)
      begin
        awready <= 1'b1;
        wready <= 1'b1;
      end
    end
  end

  // ------------------------------------------------------------------
  // mode register
  // ------------------------------------------------------------------
  logic ctrl_depth;
  logic ctrl_first;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      ctrl_depth <= 1'b0;
      ctrl_first <= 1'b0;
    end
    else if (ce && wr_fire && wstrb[0] && awaddr == FXC_REG_CTRL)
    begin
      ctrl_depth <= wdata[FXC_CTRL_DEPTH];
      ctrl_first <= wdata[FXC_CTRL_FIRST];
    end
  end

  // single mode grounds the device's token input; depth mode leaves it to the chain
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      chain_token_in_n <= 1'b0;
      chain_token_in_oe_n <= 1'b1;
    end
    else if (ce)
    begin
      chain_token_in_n <= 1'b0;
      chain_token_in_oe_n <= ctrl_depth;
    end
  end

  // ------------------------------------------------------------------
  // strobe sequencer
  // ------------------------------------------------------------------
  fxc_op_t op;
  logic [FXC_CNT_W-1:0] cnt;
  logic refused;
  logic [FXC_WORD_W-1:0] rd_word;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      state <= FXC_IDLE;
      op <= FXC_OP_CLEAR;
      op_pend <= 1'b0;
      cnt <= FXC_CNT_ZERO;
      refused <= 1'b0;
      rd_word <= '0;
      clear_n <= 1'b1;
      write_n <= 1'b1;
      read_n <= 1'b1;
      first_or_rewind_n <= 1'b1;
      fifo_wdata <= '0;
    end
    else if (ce)
    begin
      if (wr_fire && wstrb[0] && awaddr == FXC_REG_WDATA)
      begin
        op_pend <= 1'b1;
        op <= FXC_OP_WRITE;
        fifo_wdata <= wdata[FXC_WORD_W-1:0];
      end
      else if (wr_fire && wstrb[0] && awaddr == FXC_REG_CMD)
      begin
        op_pend <= wdata[FXC_CMD_CLEAR] | wdata[FXC_CMD_REWIND] | wdata[FXC_CMD_READ];
        if (wdata[FXC_CMD_CLEAR])
          op <= FXC_OP_CLEAR;
        else if (wdata[FXC_CMD_REWIND])
          op <= FXC_OP_REWIND;
        else
          op <= FXC_OP_READ;
      end
      case (state)
        FXC_IDLE:
        begin
          if (op_pend)
          begin
            op_pend <= 1'b0;
            refused <= 1'b0;
            cnt <= FXC_STROBE_LAST;
            state <= FXC_ACT;
            case (op)
              FXC_OP_CLEAR:
              begin
                clear_n <= 1'b0;
                first_or_rewind_n <= !(ctrl_depth && ctrl_first);
              end
              FXC_OP_WRITE:
              begin
                if (!sync_full_n)
                begin
                  refused <= 1'b1;
                  state <= FXC_IDLE;
                end
                else
                  write_n <= 1'b0;
              end
              FXC_OP_READ:
              begin
                cnt <= FXC_READ_LAST;
                if (!sync_empty_n)
                begin
                  refused <= 1'b1;
                  state <= FXC_IDLE;
                end
                else
                  read_n <= 1'b0;
              end
              FXC_OP_REWIND:
              begin
                if (ctrl_depth)
                begin
                  refused <= 1'b1;
                  state <= FXC_IDLE;
                end
                else
                  first_or_rewind_n <= 1'b0;
              end
              default:
                state <= FXC_IDLE;
            endcase
          end
        end
        FXC_ACT:
        begin
          if (cnt == FXC_CNT_ZERO)
          begin
            if (!read_n)
              rd_word <= sync_rdata;
            clear_n <= 1'b1;
            write_n <= 1'b1;
            read_n <= 1'b1;
            if (op == FXC_OP_REWIND)
              first_or_rewind_n <= 1'b1;
            cnt <= FXC_RECOV_LAST;
            state <= FXC_REC;
          end
          else
            cnt <= cnt - FXC_CNT_ONE;
        end
        FXC_REC:
        begin
          // the first-load strap is held through reset recovery
          if (cnt == FXC_CNT_ZERO)
          begin
            first_or_rewind_n <= 1'b1;
            state <= FXC_IDLE;
          end
          else
            cnt <= cnt - FXC_CNT_ONE;
        end
        default:
          state <= FXC_IDLE;
      endcase
    end
  end

  // ------------------------------------------------------------------
  // axi read channel
  // ------------------------------------------------------------------
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      arready <= 1'b0;
      rvalid <= 1'b0;
      rdata <= 32'h0000_0000;
      rresp <= FXC_RESP_OKAY;
    end
    else if (ce)
    begin
      if (arready)
      begin
        arready <= 1'b0;
        rvalid <= 1'b1;
        rdata <= 32'h0000_0000;
        rresp <= FXC_RESP_OKAY;
        if (araddr == FXC_REG_CTRL)
        begin
          rdata[FXC_CTRL_DEPTH] <= ctrl_depth;
          rdata[FXC_CTRL_FIRST] <= ctrl_first;
        end
        else if (araddr == FXC_REG_RDATA)
          rdata[FXC_WORD_W-1:0] <= rd_word;
        else if (araddr == FXC_REG_STATUS)
        begin
          // flags are taken from this one device only
          rdata[FXC_ST_BUSY] <= (state != FXC_IDLE) || op_pend;
          rdata[FXC_ST_EMPTY] <= !sync_empty_n;
          rdata[FXC_ST_FULL] <= !sync_full_n;
          rdata[FXC_ST_HALF] <= !sync_half_n && !ctrl_depth;
          rdata[FXC_ST_REFUSED] <= refused;
        end
        else if (araddr != FXC_REG_CMD && araddr != FXC_REG_WDATA)
          rresp <= FXC_RESP_SLVERR;
      end
      else if (rvalid)
      begin
        if (rready)
          rvalid <= 1'b0;
      end
      else if (arvalid)
        arready <= 1'b1;
    end
  end

  // ------------------------------------------------------------------
  // assertions
  // ------------------------------------------------------------------
  localparam int C_WLOW = FXC_STROBE_CYC;

  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn || !ce);

  property p_no_rewind_depth;
    ctrl_depth && op == FXC_OP_REWIND |-> first_or_rewind_n;
  endproperty
  a_no_rewind_depth: assert property (p_no_rewind_depth)
    else $error("rewind driven in depth mode");

  property p_first_strap;
    !clear_n |-> first_or_rewind_n == !(ctrl_depth && ctrl_first);
  endproperty
  a_first_strap: assert property (p_first_strap)
    else $error("first-load strap wrong during clear");

  property p_token_single;
    $rose(clear_n) && !ctrl_depth |-> !chain_token_in_oe_n && !chain_token_in_n;
  endproperty
  a_token_single: assert property (p_token_single)
    else $error("token input not grounded in single mode");

  property p_wr_full;
    $fell(write_n) |-> $past(sync_full_n, 1);
  endproperty
  a_wr_full: assert property (p_wr_full)
    else $error("write strobe while full");

  property p_rd_empty;
    $fell(read_n) |-> $past(sync_empty_n, 1);
  endproperty
  a_rd_empty: assert property (p_rd_empty)
    else $error("read strobe while empty");

  property p_wr_width;
    $fell(write_n) |-> ##C_WLOW $rose(write_n);
  endproperty
  a_wr_width: assert property (p_wr_width)
    else $error("write strobe width wrong");

  property p_status_flags;
    arready && araddr == FXC_REG_STATUS |=>
      rdata[FXC_ST_FULL] == !$past(sync_full_n, 1) &&
      rdata[FXC_ST_EMPTY] == !$past(sync_empty_n, 1);
  endproperty
  a_status_flags: assert property (p_status_flags)
    else $error("status flags do not follow device pins");

endmodule
`default_nettype wire

// *** fxc_dev_model.sv ***
// fxc_dev_model: behavioural strobe-driven fifo device facing the host controller
// assumes strobes from fxc_host pins; depth is shortened so flags are reachable
`timescale 1ns/1ps
`default_nettype none
module fxc_dev_model
  import fxc_pkg::*;
#(
  parameter int DEPTH = 8
) (
  // strobes and straps
  input wire logic clear_n,
  input wire logic write_n,
  input wire logic read_n,
  input wire logic first_or_rewind_n,
  input wire logic chain_token_in_n,
  input wire logic [fxc_pkg::FXC_WORD_W-1:0] wdata,
  // data and flags
  output logic [fxc_pkg::FXC_WORD_W-1:0] rdata,
  output logic empty_flag_n,
  output logic full_flag_n,
  output logic half_marker_n,
  output logic chain_token_out_n
);
  import fxc_pkg::*;
  logic [FXC_WORD_W-1:0] mem [DEPTH];
  logic [FXC_WORD_W-1:0] last_q = '0;
  int wp = 0;
  int rp = 0;
  int cnt = 0;
  int tokens = 0;
  logic depth_mode = 1'b0;
  logic first = 1'b1;
  logic w_go = 1'b0;
  logic r_go = 1'b0;

  assign empty_flag_n = (cnt != 0);
  assign full_flag_n = (cnt != DEPTH);
  assign half_marker_n = depth_mode | (cnt <= DEPTH / 2);
  // released data lines show the inverse of the last word, never a stale copy
  assign rdata = r_go ? mem[rp] : ~last_q;
  assign chain_token_out_n = ~((w_go && wp == DEPTH - 1) || (r_go && rp == DEPTH - 1));

  always @(clear_n)
    if (!clear_n)
    begin
      wp = 0;
      rp = 0;
      cnt = 0;
      tokens = 0;
    end
    else
    begin
      depth_mode = chain_token_in_n;
      first = depth_mode ? !first_or_rewind_n : 1'b1;
    end

  always @(negedge chain_token_in_n)
    if (depth_mode && clear_n)
      tokens = tokens + 1;

  always @(negedge write_n)
  begin
    w_go = clear_n && cnt < DEPTH && (first || tokens > 0);
    if (w_go)
      cnt = cnt + 1;
  end

  always @(posedge write_n)
    if (w_go)
    begin
      mem[wp] = wdata;
      wp = (wp + 1) % DEPTH;
      w_go = 1'b0;
    end

  always @(negedge read_n)
    r_go = clear_n && cnt > 0 && (first || tokens > 1);

  always @(posedge read_n)
    if (r_go)
    begin
      last_q = mem[rp];
      rp = (rp + 1) % DEPTH;
      cnt = cnt - 1;
      r_go = 1'b0;
    end

  always @(negedge first_or_rewind_n)
    if (clear_n && !depth_mode)
    begin
      rp = 0;
      cnt = wp;
    end
endmodule
`default_nettype wire

// *** fxc_host_tb_top.sv ***
// fxc_host_tb_top: register-level tests of the fifo host controller
// assumes fxc_dev_model on the pins and a pull-up on the released token line
`timescale 1ns/1ps
`default_nettype none
module fxc_host_tb_top;
  import fxc_pkg::*;
  localparam int DEPTH = 8;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [FXC_ADDR_W-1:0] awaddr = '0;
  logic [FXC_ADDR_W-1:0] araddr = '0;
  logic [31:0] wdata = '0;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic tb_tok = 1'b1;
  logic awready, wready, bvalid, arready, rvalid, clear_n, write_n, read_n, fr_n;
  logic tok_n, tok_oe_n, empty_n, full_n, half_n, tok_line;
  logic [1:0] bresp, rresp, resp;
  logic [31:0] rdata, v;
  logic [FXC_WORD_W-1:0] fw, fr;
  int bad_count = 0;
  int total_checks = 0;

  always #2.5 aclk = ~aclk;
  assign tok_line = tok_oe_n ? tb_tok : tok_n;

  fxc_host fxc_host_i (.aclk(aclk), .aresetn(aresetn), .ce(1'b1), .awaddr(awaddr),
    .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(4'hf), .wvalid(wvalid),
    .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr),
    .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
    .rready(rready), .clear_n(clear_n), .write_n(write_n), .read_n(read_n),
    .first_or_rewind_n(fr_n), .chain_token_in_n(tok_n), .chain_token_in_oe_n(tok_oe_n),
    .fifo_wdata(fw), .fifo_rdata(fr), .empty_flag_n(empty_n), .full_flag_n(full_n),
    .half_marker_n(half_n));

  fxc_dev_model #(.DEPTH(DEPTH)) fxc_dev_model_i (.clear_n(clear_n), .write_n(write_n),
    .read_n(read_n), .first_or_rewind_n(fr_n), .chain_token_in_n(tok_line), .wdata(fw),
    .rdata(fr), .empty_flag_n(empty_n), .full_flag_n(full_n), .half_marker_n(half_n),
    .chain_token_out_n());

  // ------------------------------------------------------------------
  // reporting
  // ------------------------------------------------------------------
  task automatic stop_test;
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string msg);
    total_checks++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("[FAIL] %0t %s seen %h expected %h", $time, msg, seen, exp);
    end
  endtask

  task automatic hang(input string msg);
    bad_count++;
    $display("[FAIL] %0t timeout in %s", $time, msg);
    stop_test();
  endtask

  // ------------------------------------------------------------------
  // axi4-lite master
  // ------------------------------------------------------------------
  task automatic axi_wr(input logic [FXC_ADDR_W-1:0] a, input logic [31:0] d,
                        output logic [1:0] r);
    int n;
    logic got;
    n = 0;
    got = 1'b0;
    r = 2'h3;
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!got && n < 400)
    begin
      @(posedge aclk);
      n++;
      if (awready === 1'b1)
        awvalid <= 1'b0;
      if (wready === 1'b1)
        wvalid <= 1'b0;
      if (bvalid === 1'b1)
      begin
        got = 1'b1;
        r = bresp;
      end
    end
    bready <= 1'b0;
    if (!got)
      hang("write");
  endtask

  task automatic axi_rd(input logic [FXC_ADDR_W-1:0] a, output logic [31:0] d,
                        output logic [1:0] r);
    int n;
    logic got;
    n = 0;
    got = 1'b0;
    d = '0;
    r = 2'h3;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    while (!got && n < 400)
    begin
      @(posedge aclk);
      n++;
      if (arready === 1'b1)
        arvalid <= 1'b0;
      if (rvalid === 1'b1)
      begin
        got = 1'b1;
        d = rdata;
        r = rresp;
      end
    end
    rready <= 1'b0;
    if (!got)
      hang("read");
  endtask

  // register write, then wait until the device operation has finished
  task automatic op(input logic [FXC_ADDR_W-1:0] a, input logic [31:0] d);
    int n;
    n = 0;
    axi_wr(a, d, resp);
    check({30'h0, resp}, {30'h0, FXC_RESP_OKAY}, "bresp");
    v = 32'h1;
    while (v[FXC_ST_BUSY] !== 1'b0 && n < 100)
    begin
      axi_rd(FXC_REG_STATUS, v, resp);
      n++;
    end
    if (v[FXC_ST_BUSY] !== 1'b0)
      hang("busy");
  endtask

  // expected bits are refused, half, full, empty
  task automatic st_chk(input logic [3:0] e);
    axi_rd(FXC_REG_STATUS, v, resp);
    check({28'h0, v[FXC_ST_REFUSED:FXC_ST_EMPTY]}, {28'h0, e}, "status");
  endtask

  task automatic rd_word(input logic [FXC_WORD_W-1:0] e);
    axi_rd(FXC_REG_RDATA, v, resp);
    check({23'h0, v[8:0]}, {23'h0, e}, "read word");
  endtask

  function automatic logic [FXC_WORD_W-1:0] word(input int i);
    return 9'(9'h0a5 + i * 59);
  endfunction

  // ------------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------------
  initial
  begin
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    op(FXC_REG_CTRL, 32'h0);
    op(FXC_REG_CMD, 32'h1);
    st_chk(4'b0001);
    for (int i = 0; i < DEPTH; i++)
    begin
      op(FXC_REG_WDATA, {23'h0, word(i)});
      st_chk({1'b0, i >= DEPTH / 2, i == DEPTH - 1, 1'b0});
    end
    op(FXC_REG_WDATA, 32'h0ff);
    st_chk(4'b1110);
    for (int i = 0; i < DEPTH; i++)
    begin
      op(FXC_REG_CMD, 32'h4);
      rd_word(word(i));
      st_chk({1'b0, (DEPTH - 1 - i) > DEPTH / 2, 1'b0, i == DEPTH - 1});
    end
    op(FXC_REG_CMD, 32'h4);
    st_chk(4'b1001);
    op(FXC_REG_CMD, 32'h1);
    op(FXC_REG_WDATA, {23'h0, word(10)});
    op(FXC_REG_WDATA, {23'h0, word(11)});
    op(FXC_REG_CMD, 32'h4);
    op(FXC_REG_CMD, 32'h2);
    op(FXC_REG_CMD, 32'h4);
    rd_word(word(10));
    st_chk(4'b0000);
    axi_wr(5'h14, 32'h0, resp);
    check({30'h0, resp}, {30'h0, FXC_RESP_SLVERR}, "unmapped write");
    axi_rd(5'h1c, v, resp);
    check({30'h0, resp}, {30'h0, FXC_RESP_SLVERR}, "unmapped read");
    op(FXC_REG_CTRL, 32'h3);
    axi_rd(FXC_REG_CTRL, v, resp);
    check({30'h0, v[1:0]}, 32'h3, "ctrl readback");
    op(FXC_REG_CMD, 32'h1);
    for (int i = 0; i < DEPTH / 2 + 2; i++)
      op(FXC_REG_WDATA, {23'h0, word(i)});
    st_chk(4'b0000);
    op(FXC_REG_CMD, 32'h2);
    st_chk(4'b1000);
    op(FXC_REG_CTRL, 32'h1);
    op(FXC_REG_CMD, 32'h1);
    op(FXC_REG_WDATA, {23'h0, word(1)});
    st_chk(4'b0001);
    for (int k = 0; k < 2; k++)
    begin
      // token pulse, well clear of the following strobe
      tb_tok <= 1'b0;
      repeat (20) @(posedge aclk);
      tb_tok <= 1'b1;
      repeat (20) @(posedge aclk);
      if (k == 0)
      begin
        op(FXC_REG_WDATA, {23'h0, word(2)});
        st_chk(4'b0000);
        op(FXC_REG_CMD, 32'h4);
        st_chk(4'b0000);
      end
    end
    op(FXC_REG_CMD, 32'h4);
    rd_word(word(2));
    st_chk(4'b0001);
    stop_test();
  end
endmodule
`default_nettype wire
